// file: design/snp_packer.sv
// Top level of the sensor frame nibble packer with its register file.
`timescale 1ns/1ps
`include "snp_regs.svh"
module snp_packer #(
  parameter int TICK_CYCLES = `SNP_TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [11:0] sample_value,
  input wire logic ch1_error,
  input wire logic ch2_error,
  input wire logic [1:0] serial_bits,
  output logic frame_valid,
  input wire logic frame_ready,
  output snp_pkg::snp_frame_t frame,
  output logic tick
);
  import snp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  snp_reg_wr_t reg_wr;

  snp_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .reg_wr(reg_wr)
  );

  logic [31:0] ctrl;
  logic [7:0] counter;
  logic [15:0] frames_sent;
  snp_format_t format;
  logic hs_err_en;
  logic hs_ser_en;
  logic diag_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `SNP_CTRL_RESET;
    end else if (reg_wr.en && reg_wr.addr == `SNP_ADDR_CTRL) begin
      ctrl <= {27'h000_0000, reg_wr.data[4:0]};
    end
  end

  assign format = snp_format_t'(ctrl[`SNP_CTRL_FMT_HI:`SNP_CTRL_FMT_LO]);
  assign hs_err_en = ctrl[`SNP_CTRL_HS_ERR_EN];
  assign hs_ser_en = ctrl[`SNP_CTRL_HS_SER_EN];
  assign diag_mode = ctrl[`SNP_CTRL_DIAG];

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    if (rd_addr == `SNP_ADDR_CTRL) begin
      rd_data = ctrl;
    end else if (rd_addr == `SNP_ADDR_STATUS) begin
      rd_data = {20'h0_0000, frame.num_data, frame_valid, counter};
    end else if (rd_addr == `SNP_ADDR_LAST) begin
      rd_data = {4'h0, frame.data, frame.status};
    end else if (rd_addr == `SNP_ADDR_FRAMES) begin
      rd_data = {16'h0000, frames_sent};
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider for the transmitter.

  logic [15:0] tick_cnt;

  // nominal tick period from the clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame assembly.

  logic take_sample;
  logic hand_over;
  logic [11:0] value_adj;
  logic [3:0] next_status;
  snp_frame_t next_frame;

  assign sample_ready = !frame_valid;
  assign take_sample = sample_valid && sample_ready;
  assign hand_over = frame_valid && frame_ready;

  // high-speed full scale held back outside diagnostic mode.
  always_comb begin
    if (!diag_mode && format == SNP_FMT_HIGH_SPEED &&
        sample_value == `SNP_FULL_SCALE) begin
      value_adj = `SNP_DIAG_CLAMP;
    end else begin
      value_adj = sample_value;
    end
  end

  always_comb begin
    if (format == SNP_FMT_HIGH_SPEED) begin
      next_status[0] = hs_err_en && ch1_error;
      next_status[1] = ch2_error;
      // serial bits stay zero unless enabled.
      next_status[3:2] = hs_ser_en ? serial_bits : 2'b00;
    end else begin
      next_status[0] = ch1_error;
      // channel two flag and serial data.
      next_status[1] = ch2_error;
      next_status[3:2] = serial_bits;
    end
  end

  // high-speed nibbles are built with a zero top bit.
  snp_nibble_map u_map (
    .format(format),
    .value(value_adj),
    .status(next_status),
    .counter(counter),
    .frame(next_frame)
  );

  // frame carries its own data nibble count; rest stay zero.
  // nibbles pass out unchanged from the map, with no further format tweak.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame <= '0;
    end else if (take_sample) begin
      frame <= next_frame;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_valid <= 1'b0;
    end else if (take_sample) begin
      frame_valid <= 1'b1;
    end else if (hand_over) begin
      frame_valid <= 1'b0;
    end
  end

  // one step per secure frame, zero from reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter <= 8'h00;
    end else if (take_sample && format == SNP_FMT_SECURE) begin
      counter <= counter + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frames_sent <= 16'h0000;
    end else if (hand_over) begin
      frames_sent <= frames_sent + 16'h0001;
    end
  end

endmodule

// file: design/snp_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SNP_REGS_SVH
`define SNP_REGS_SVH

`define SNP_ADDR_CTRL 8'h00
`define SNP_ADDR_STATUS 8'h04
`define SNP_ADDR_LAST 8'h08
`define SNP_ADDR_FRAMES 8'h0C

`define SNP_CTRL_FMT_LO 0
`define SNP_CTRL_FMT_HI 1
`define SNP_CTRL_HS_ERR_EN 2
`define SNP_CTRL_HS_SER_EN 3
`define SNP_CTRL_DIAG 4
`define SNP_CTRL_RESET 32'h0000_0000

`define SNP_NIB_SINGLE 3'h3
`define SNP_NIB_HS 3'h4
`define SNP_NIB_SECURE 3'h6
`define SNP_NIB_MAX 15
`define SNP_FULL_SCALE 12'hFFF
`define SNP_DIAG_CLAMP 12'hFFE

`define SNP_CLK_PERIOD_NS 100
`define SNP_TICK_NS 2670
`define SNP_TICK_CYCLES (`SNP_TICK_NS / `SNP_CLK_PERIOD_NS)

`endif

// file: design/snp_pkg.sv
// Types shared by the nibble packer modules.
package snp_pkg;

  typedef enum logic [1:0] {
    SNP_FMT_SINGLE,
    SNP_FMT_HIGH_SPEED,
    SNP_FMT_SECURE
  } snp_format_t;

  typedef struct packed {
    logic [2:0] num_data;
    logic [3:0] status;
    logic [5:0][3:0] data;
  } snp_frame_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } snp_reg_wr_t;

endpackage

// file: design/snp_ahb_slave.sv
// AHB-Lite slave front end for the packer register file.
`timescale 1ns/1ps
module snp_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  output snp_pkg::snp_reg_wr_t reg_wr
);
  import snp_pkg::*;

  logic wr_pend;
  logic [7:0] wr_addr;
  logic take;

  // A transfer is taken on NONSEQ or SEQ while the bus is ready.
  assign take = hsel && hready && htrans[1];
  assign rd_addr = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite && (hsize == 3'h2);
      wr_addr <= haddr[7:0];
    end
  end

  // Read data is captured in the address phase and shown in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_data;
    end
  end

  always_comb begin
    reg_wr.en = wr_pend;
    reg_wr.addr = wr_addr;
    reg_wr.data = hwdata;
  end

endmodule

// file: design/snp_nibble_map.sv
// Combinational placement of a measurement into frame nibbles.
`timescale 1ns/1ps
`include "snp_regs.svh"
module snp_nibble_map (
  input wire snp_pkg::snp_format_t format,
  input wire logic [11:0] value,
  input wire logic [3:0] status,
  input wire logic [7:0] counter,
  output snp_pkg::snp_frame_t frame
);
  import snp_pkg::*;

  logic [3:0][3:0] hs_nib;

  // HS split: value bits in groups of three, top bit of each nibble zero.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_hs
      assign hs_nib[gi] = {1'b0, value[11 - 3 * gi -: 3]};
    end
  endgenerate

  always_comb begin
    frame.status = status;
    frame.data = '0;
    case (format)
      SNP_FMT_HIGH_SPEED: begin
        frame.num_data = `SNP_NIB_HS;
        frame.data[0] = hs_nib[0];
        frame.data[1] = hs_nib[1];
        frame.data[2] = hs_nib[2];
        frame.data[3] = hs_nib[3];
      end
      SNP_FMT_SECURE: begin
        frame.num_data = `SNP_NIB_SECURE;
        frame.data[0] = value[11:8];
        frame.data[1] = value[7:4];
        frame.data[2] = value[3:0];
        frame.data[3] = counter[7:4];
        frame.data[4] = counter[3:0];
        frame.data[5] = 4'(`SNP_NIB_MAX) - value[11:8];
      end
      default: begin
        frame.num_data = `SNP_NIB_SINGLE;
        frame.data[0] = value[11:8];
        frame.data[1] = value[7:4];
        frame.data[2] = value[3:0];
      end
    endcase
  end

endmodule

// file: bench/snp_packer_asserts.sv
// Assertions on the packer sample and frame ports.
`timescale 1ns/1ps
module snp_packer_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [11:0] sample_value,
  input wire logic ch1_error,
  input wire logic ch2_error,
  input wire logic frame_valid,
  input wire snp_pkg::snp_frame_t frame
);
  import snp_pkg::*;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_take;
    sample_valid && sample_ready;
  endsequence
  sequence s_full;
    s_take ##1 frame.num_data != 3'h4;
  endsequence
  sequence s_hs;
    s_take ##1 frame.num_data == 3'h4 && $past(sample_value) != 12'hFFF;
  endsequence
  property p_num;
    frame_valid |-> frame.num_data inside {3'h3, 3'h4, 3'h6};
  endproperty
  a_num: assert property (p_num) else $error("bad count");
  property p_zero;
    frame_valid && frame.num_data == 3'h3 |-> frame.data[5:3] == 12'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("unused set");
  property p_top;
    frame_valid && frame.num_data == 3'h4 |-> (frame.data & 24'h888888) == 0;
  endproperty
  a_top: assert property (p_top) else $error("top bit set");
  property p_inv;
    frame_valid && frame.num_data == 3'h6 |->
      frame.data[5] == 4'hF - frame.data[0];
  endproperty
  a_inv: assert property (p_inv) else $error("bad copy");
  property p_msn;
    s_full |-> {frame.data[0], frame.data[1], frame.data[2]} ==
      $past(sample_value);
  endproperty
  a_msn: assert property (p_msn) else $error("bad order");
  property p_err;
    s_full |-> frame.status[0] == $past(ch1_error);
  endproperty
  a_err: assert property (p_err) else $error("bad flag");
  property p_hs;
    s_hs |-> {frame.data[0][2:0], frame.data[1][2:0], frame.data[2][2:0],
      frame.data[3][2:0]} == $past(sample_value);
  endproperty
  a_hs: assert property (p_hs) else $error("bad split");
  property p_ch2;
    s_take |=> frame.status[1] == $past(ch2_error);
  endproperty
  a_ch2: assert property (p_ch2) else $error("bad flag two");
endmodule
bind snp_packer snp_packer_asserts u_chk (.hclk, .hresetn, .sample_valid,
  .sample_ready, .sample_value, .ch1_error, .ch2_error, .frame_valid,
  .frame);

// file: bench/snp_rx_model.sv
// Receiving controller model that takes frames after a set delay.
`timescale 1ns/1ps
module snp_rx_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic frame_valid,
  input wire snp_pkg::snp_frame_t frame,
  input wire logic [3:0] delay,
  output logic frame_ready,
  output snp_pkg::snp_frame_t rx_frame,
  output logic [15:0] rx_count
);
  import snp_pkg::*;
  logic [3:0] wait_n;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_ready <= 1'b0;
      wait_n <= 4'h0;
      rx_frame <= '0;
      rx_count <= 16'h0000;
    end else if (frame_valid && !frame_ready) begin
      if (wait_n >= delay) begin
        frame_ready <= 1'b1;
      end else begin
        wait_n <= wait_n + 4'h1;
      end
    end else begin
      frame_ready <= 1'b0;
      wait_n <= 4'h0;
      if (frame_valid) begin
        rx_frame <= frame;
        rx_count <= rx_count + 16'h0001;
      end
    end
  end
endmodule

// file: bench/snp_packer_tb.sv
// Self-checking bench for the nibble packer.
`timescale 1ns/1ps
module snp_packer_tb;
  import snp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, frame_valid;
  logic sample_valid, sample_ready, ch1_error, ch2_error, frame_ready;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, serial_bits;
  logic [2:0] hsize;
  logic [11:0] sample_value;
  logic [3:0] delay;
  logic [15:0] rx_count;
  logic tick;
  snp_frame_t frame, rx_frame;
  int err_total = 0;
  int comparisons = 0;
  snp_packer #(.TICK_CYCLES(4)) dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hreadyout,
    .hresp, .hrdata, .sample_valid, .sample_ready, .sample_value,
    .ch1_error, .ch2_error, .serial_bits, .frame_valid, .frame_ready,
    .frame, .tick);
  snp_rx_model rx (.hclk, .hresetn, .frame_valid, .frame, .delay,
    .frame_ready, .rx_frame, .rx_count);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [38:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input int d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic send(input logic [11:0] v, input logic [3:0] e);
    logic [15:0] n;
    n = rx_count;
    sample_value <= v;
    {serial_bits, ch2_error, ch1_error} <= e;
    sample_valid <= 1'b1;
    do @(posedge hclk); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
    repeat (30) if (rx_count == n) @(posedge hclk);
    chk("rx count", {23'h0, n + 16'h0001}, {23'h0, rx_count});
  endtask
  task automatic t_regs;
    ahb(1'b0, 8'h00, 0);
    chk("ctrl", 39'h0, {7'h0, q});
    ahb(1'b1, 8'h10, -1);
    ahb(1'b0, 8'h10, 0);
    chk("hole", 39'h0, {7'h0, q});
    ahb(1'b0, 8'h04, 0);
    chk("count", 39'h0, {6'h0, hresp, q});
  endtask
  task automatic t_tick;
    int gap;
    gap = 0;
    do @(posedge hclk); while (tick !== 1'b1);
    do begin
      @(posedge hclk);
      gap++;
    end while (tick !== 1'b1 && gap < 20);
    chk("tick gap", 39'h4, 39'(gap));
  endtask
  task automatic t_single;
    for (int f = 0; f < 4; f += 3) begin
      ahb(1'b1, 8'h00, f);
      send(12'hA5C, 4'hD);
      chk("single", {7'h3D, 24'h000C5A}, rx_frame);
    end
  endtask
  task automatic t_hs;
    ahb(1'b1, 8'h00, 1);
    delay <= 4'h5;
    send(12'hFFF, 4'hF);
    chk("hs clamp", {7'h42, 24'h006777}, rx_frame);
    ahb(1'b1, 8'h00, 29);
    send(12'hFFF, 4'hF);
    chk("hs diag", {7'h4F, 24'h007777}, rx_frame);
    send(12'h5A3, 4'h5);
    chk("hs bits", {7'h45, 24'h003462}, rx_frame);
    delay <= 4'h0;
  endtask
  task automatic t_sec;
    logic [11:0] v;
    logic [7:0] c;
    ahb(1'b1, 8'h00, 2);
    for (int i = 0; i < 257; i++) begin
      v = {i[3:0], 8'h7B};
      c = i[7:0];
      send(v, 4'h1);
      chk("secure", {7'h61, 4'hF - v[11:8], c[3:0], c[7:4], v[3:0],
        v[7:4], v[11:8]}, rx_frame);
    end
    ahb(1'b0, 8'h04, 0);
    chk("wrap", 39'h1, {31'h0, q[7:0]});
    ahb(1'b0, 8'h08, 0);
    chk("last", 39'h0F00B701, {7'h0, q});
    ahb(1'b0, 8'h0C, 0);
    chk("frames", 39'h106, {7'h0, q});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h04, 0);
    chk("restart", 39'h0, {7'h0, q});
  endtask
  initial begin
    {hresetn, hwrite, sample_valid, ch1_error, ch2_error} = '0;
    {haddr, hwdata, htrans, serial_bits, sample_value, delay} = '0;
    hsel = 1'b1;
    hsize = 3'b010;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_tick;
    t_single;
    t_hs;
    t_sec;
    test_done;
  end
  initial begin
    #3_000_000;
    err_total++;
    test_done;
  end
endmodule
